// file: dv/spv_gear_model.sv
`timescale 1ns/1ps
module spv_gear_model (
    // Clock
    input wire logic          hclk,
    // Command from the validator; travel 0 means a stuck mechanism
    input spv_pkg::spv_cmd_s  cmd_out,
    input wire logic [31:0]   travel_cyc,
    input wire logic [1:0]    preset,
    input wire logic          preset_en,
    // Contacts
    output spv_pkg::spv_aux_s aux_in
);
    int   cnt;
    logic to_close;
    always @(posedge hclk) begin
        if (preset_en) begin
            aux_in <= preset;
            cnt <= 0;
        end else if ((cmd_out.close || cmd_out.open) && cnt == 0 &&
                     travel_cyc != 0 &&
                     aux_in != (cmd_out.open ? 2'h1 : 2'h2)) begin
            // Both contacts part while the mechanism travels
            cnt <= travel_cyc;
            to_close <= !cmd_out.open;
            aux_in <= 2'h0;
        end else if (cnt == 1) begin
            aux_in <= to_close ? 2'h2 : 2'h1;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// file: dv/spv_sva.sv
`timescale 1ns/1ps
module spv_sva (
    // Clock and reset
    input wire logic          hclk,
    input wire logic          hresetn,
    // Register bus
    input wire logic          hsel,
    input wire logic          hready,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic          hreadyout,
    input wire logic [31:0]   hrdata,
    input wire logic          hresp,
    // Switchgear side and status
    input spv_pkg::spv_cmd_s  cmd_out,
    input wire logic [1:0]    pos_code,
    input spv_pkg::spv_flags_s pos_flags,
    input wire logic          switch_success_flag
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Longest command allowed with the default travel time of 1000 us
    logic [17:0] cnt_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= 18'h00000;
        end else if (cmd_out.close || cmd_out.open) begin
            cnt_reg <= cnt_reg + 18'h00001;
        end else begin
            cnt_reg <= 18'h00000;
        end
    end

    a_flags_onehot: assert property ($onehot(pos_flags))
        else $error("position flags not one-hot");
    a_code_flags: assert property (
        pos_flags.fault == (pos_code == spv_pkg::POS_FAULT) &&
        pos_flags.inter == (pos_code == spv_pkg::POS_INTER) &&
        pos_flags.open == (pos_code == spv_pkg::POS_OPEN) &&
        pos_flags.closed == (pos_code == spv_pkg::POS_CLOSED))
        else $error("flags disagree with position code");
    a_cmd_excl: assert property (!(cmd_out.close && cmd_out.open))
        else $error("both command outputs active");
    a_cmd_limit: assert property (cnt_reg <= 18'h1E848)
        else $error("command output held past travel time");
    a_success_drop: assert property ($rose(switch_success_flag) |->
        !cmd_out.close && !cmd_out.open ##1
        (pos_code == spv_pkg::POS_CLOSED || pos_code == spv_pkg::POS_OPEN))
        else $error("success without end position");
    a_success_clear: assert property ($fell(switch_success_flag) |->
        $rose(cmd_out.close) || $rose(cmd_out.open))
        else $error("success dropped without new command");
    a_bus_okay: assert property (
        hreadyout && hresp == spv_pkg::HRESP_OKAY)
        else $error("bus slave stalled or answered error");
    a_rdata_idle: assert property (
        !$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
        else $error("read data outside read data phase");
endmodule

bind spv_validator spv_sva i_sva (.hclk, .hresetn, .hsel, .hready, .htrans,
    .hwrite, .hreadyout, .hrdata, .hresp, .cmd_out, .pos_code, .pos_flags,
    .switch_success_flag);

// file: dv/test_switchgear_position_validator.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
    err_count++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module test_switchgear_position_validator;
    logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdat;
    logic [1:0] htrans = 2'h0, preset = 2'h1, pos_code;
    logic hreadyout, hresp, preset_en = 1'b1;
    logic single_contact_flag, switch_success_flag;
    logic [31:0] hrdata;
    spv_pkg::spv_cmd_s cmd_in = 2'h0, cmd_out;
    spv_pkg::spv_aux_s aux_in;
    spv_pkg::spv_flags_s pos_flags;
    int travel = 0, err_count = 0, compares = 0;
    // Rows: wiring, close, moves, settle, expected code
    logic [6:0] rows [10] = '{7'h7A, 7'h69, 7'h73, 7'h3A, 7'h33, 7'h36,
                              7'h29, 7'h49, 7'h43, 7'h45};
    assign hready = hreadyout;

    spv_validator #(.DEF_MOVE_CLOSE_US(16'h0002),
        .DEF_MOVE_OPEN_US(16'h0002)) i_dut (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout,
        .hrdata, .hresp, .aux_in, .cmd_in, .cmd_out, .pos_code, .pos_flags,
        .single_contact_flag, .switch_success_flag);
    spv_gear_model i_gear (.hclk, .cmd_out, .travel_cyc(travel), .preset,
        .preset_en, .aux_in);

    task automatic results();
        if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wait_ready();
        int n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            if (++n > 16) begin
                err_count++;
                results();
            end
            @(posedge hclk);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rdat = hrdata;
    endtask
    task automatic set_aux(input logic [1:0] v);
        @(posedge hclk);
        preset <= v;
        preset_en <= 1'b1;
        @(posedge hclk);
        preset_en <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask
    function automatic logic [1:0] exp_idle(input logic [1:0] w, a);
        case (w)
            spv_pkg::WIRED_BOTH: exp_idle = (a == 2'h2) ? spv_pkg::POS_CLOSED
                : (a == 2'h1) ? spv_pkg::POS_OPEN : spv_pkg::POS_FAULT;
            spv_pkg::WIRED_CLOSE: exp_idle = a[1] ? 2'h2 : 2'h1;
            spv_pkg::WIRED_OPEN: exp_idle = a[0] ? 2'h1 : 2'h2;
            default: exp_idle = spv_pkg::POS_FAULT;
        endcase
    endfunction
    task automatic run_move(input logic [6:0] r);
        logic cl = r[4];
        logic sup = (r[6:5] == 2'h3) || (cl ? r[6:5] == 2'h1 : r[6:5] == 2'h2);
        // Two contacts that never part still decode as the old end position
        logic exp_inter = sup && (r[3] || r[6:5] != 2'h3);
        int lo = r[3] ? 1 : (r[2] ? 360 : 240);
        int n;
        ahb(1'b1, spv_pkg::ADDR_CTRL, {30'h0, r[6:5]});
        ahb(1'b1, spv_pkg::ADDR_SETTLE, {31'h0, r[2]});
        set_aux(cl ? 2'h1 : 2'h2);
        travel <= r[3] ? 20 + $urandom % 180 : 0;
        if ($urandom % 2) begin
            ahb(1'b1, spv_pkg::ADDR_CMD, cl ? 32'h1 : 32'h2);
        end else begin
            cmd_in <= cl ? 2'h2 : 2'h1;
            @(posedge hclk);
            cmd_in <= 2'h0;
        end
        repeat (3) @(posedge hclk);
        `CHK("inter", exp_inter, pos_flags.inter)
        for (n = 4; n < 700 && pos_code !== r[1:0]; n++) @(posedge hclk);
        `CHK("code", r[1:0], pos_code)
        `CHK("timing", 1'b1, n >= lo)
        repeat (2) @(posedge hclk);
        `CHK("success", r[3] & sup, switch_success_flag)
        `CHK("cmd_out", 2'h0, cmd_out)
        if (pos_code !== r[1:0]) results();
    endtask

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    initial begin
        void'($urandom(91186));
        repeat (20) @(posedge hclk);
        `CHK("reset code", spv_pkg::POS_FAULT, pos_code)
        hresetn <= 1'b1;
        preset_en <= 1'b0;
        ahb(1'b0, spv_pkg::ADDR_CTRL, 32'h0);
        `CHK("ctrl", 32'h3, rdat)
        ahb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 32'h0, rdat)
        ahb(1'b1, spv_pkg::ADDR_MOVE_CLOSE, 32'h2);
        ahb(1'b0, spv_pkg::ADDR_MOVE_CLOSE, 32'h0);
        `CHK("move_close", 32'h2, rdat)
        // Every wiring against every static contact pair
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, spv_pkg::ADDR_CTRL, 32'(i));
            for (int j = 0; j < 4; j++) begin
                set_aux(2'(j));
                `CHK("code", exp_idle(2'(i), 2'(j)), pos_code)
                `CHK("single", i == 1 || i == 2, single_contact_flag)
                ahb(1'b0, spv_pkg::ADDR_STATUS, 32'h0);
                `CHK("status", exp_idle(2'(i), 2'(j)), rdat[1:0])
            end
        end
        foreach (rows[k]) run_move(rows[k]);
        results();
    end
endmodule

// file: rtl/spv_pkg.sv
package spv_pkg;

    // ************************************************************
    // Clock and time base
    // ************************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int US_NS         = 1000;
    localparam int CYC_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRESC_W       = 7;
    localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(CYC_PER_US - 1);
    localparam logic [PRESC_W-1:0] PRESC_ZERO = 7'h00;
    localparam logic [PRESC_W-1:0] PRESC_ONE  = 7'h01;

    localparam int TIME_W = 16;
    localparam logic [TIME_W-1:0] TIME_ZERO = 16'h0000;
    localparam logic [TIME_W-1:0] TIME_ONE  = 16'h0001;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL       = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CMD        = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_MOVE_CLOSE = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_MOVE_OPEN  = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_SETTLE     = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h14;

    // Wiring field of CTRL: bit 0 closed-side, bit 1 open-side
    localparam int WIRED_LSB = 0;
    localparam int WIRED_MSB = 1;
    localparam logic [1:0] WIRED_NONE  = 2'h0;
    localparam logic [1:0] WIRED_CLOSE = 2'h1;
    localparam logic [1:0] WIRED_OPEN  = 2'h2;
    localparam logic [1:0] WIRED_BOTH  = 2'h3;
    localparam logic [1:0] CTRL_RST    = WIRED_BOTH;

    localparam int CMD_CLOSE_BIT = 0;
    localparam int CMD_OPEN_BIT  = 1;

    localparam int ST_CODE_LSB   = 0;
    localparam int ST_CODE_MSB   = 1;
    localparam int ST_CLOSED_BIT = 2;
    localparam int ST_OPEN_BIT   = 3;
    localparam int ST_INTER_BIT  = 4;
    localparam int ST_FAULT_BIT  = 5;
    localparam int ST_SINGLE_BIT = 6;
    localparam int ST_SUCC_BIT   = 7;
    localparam int ST_CCMD_BIT   = 8;
    localparam int ST_OCMD_BIT   = 9;
    localparam int ST_BUSY_BIT   = 10;
    localparam int ST_AUXC_BIT   = 11;
    localparam int ST_AUXO_BIT   = 12;

    localparam int   HTRANS_ACT_BIT = 1;
    localparam logic HRESP_OKAY     = 1'b0;

    // ************************************************************
    // Position codes
    // ************************************************************
    localparam logic [1:0] POS_INTER  = 2'h0;
    localparam logic [1:0] POS_OPEN   = 2'h1;
    localparam logic [1:0] POS_CLOSED = 2'h2;
    localparam logic [1:0] POS_FAULT  = 2'h3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {PH_IDLE, PH_MOVE, PH_SETTLE} spv_phase_e;

    typedef struct packed {
        logic closed_side;
        logic open_side;
    } spv_aux_s;

    typedef struct packed {
        logic close;
        logic open;
    } spv_cmd_s;

    typedef struct packed {
        logic closed;
        logic open;
        logic inter;
        logic fault;
    } spv_flags_s;

    typedef struct packed {
        spv_phase_e               phase;
        logic                     dir_close;
        logic                     superv;
        logic [PRESC_W-1:0]       prescale;
        logic [TIME_W-1:0]        remain;
        logic                     hold_valid;
        logic [1:0]               hold_code;
        logic                     success;
        spv_cmd_s                 cmd_out;
        logic [1:0]               code;
        spv_flags_s               flags;
        logic                     single;
        logic [1:0]               wired;
        logic [TIME_W-1:0]        move_close;
        logic [TIME_W-1:0]        move_open;
        logic [TIME_W-1:0]        settle;
        spv_aux_s                 aux_prev;
        spv_cmd_s                 req_prev;
        logic                     ahb_wr;
        logic [ADDR_W-1:0]        ahb_addr;
        logic [31:0]              hrdata;
        logic                     hready;
    } spv_state_s;

endpackage

// file: rtl/spv_validator.sv
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module spv_validator #(
    parameter logic [spv_pkg::TIME_W-1:0] DEF_MOVE_CLOSE_US = 16'h03E8,
    parameter logic [spv_pkg::TIME_W-1:0] DEF_MOVE_OPEN_US  = 16'h03E8,
    parameter logic [spv_pkg::TIME_W-1:0] DEF_SETTLE_US     = 16'h0000
) (
    // Clock and reset
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    // AHB-Lite slave
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic [31:0]                      hrdata,
    output logic                             hresp,
    // Contact inputs and command triggers
    input  spv_pkg::spv_aux_s                aux_in,
    input  spv_pkg::spv_cmd_s                cmd_in,
    // Switchgear command outputs
    output spv_pkg::spv_cmd_s                cmd_out,
    // Position status
    output logic [1:0]                       pos_code,
    output spv_pkg::spv_flags_s              pos_flags,
    output logic                             single_contact_flag,
    output logic                             switch_success_flag
);

    // ************************************************************
    // State and reset value
    // ************************************************************
    localparam spv_pkg::spv_state_s ST_RST = '{
        phase:      spv_pkg::PH_IDLE,
        dir_close:  1'b0,
        superv:     1'b0,
        prescale:   spv_pkg::PRESC_ZERO,
        remain:     spv_pkg::TIME_ZERO,
        hold_valid: 1'b0,
        hold_code:  spv_pkg::POS_FAULT,
        success:    1'b0,
        cmd_out:    '{close: 1'b0, open: 1'b0},
        code:       spv_pkg::POS_FAULT,
        flags:      '{closed: 1'b0, open: 1'b0, inter: 1'b0, fault: 1'b1},
        single:     1'b0,
        wired:      spv_pkg::CTRL_RST,
        move_close: DEF_MOVE_CLOSE_US,
        move_open:  DEF_MOVE_OPEN_US,
        settle:     DEF_SETTLE_US,
        aux_prev:   '{closed_side: 1'b0, open_side: 1'b0},
        req_prev:   '{close: 1'b0, open: 1'b0},
        ahb_wr:     1'b0,
        ahb_addr:   spv_pkg::ADDR_CTRL,
        hrdata:     32'h0000_0000,
        hready:     1'b1
    };

    spv_pkg::spv_state_s s;
    spv_pkg::spv_state_s n;

    logic                       addr_ok;
    logic [spv_pkg::ADDR_W-1:0] rd_addr;
    logic                       wr_cmd;
    logic                       req_close;
    logic                       req_open;
    logic                       aux_chg;
    logic                       tick;
    logic                       expire;
    logic                       single;
    logic                       busy;
    logic                       reached;
    logic [1:0]                 target;
    logic [1:0]                 shown;

    // ************************************************************
    // Position decoding
    // ************************************************************
    function automatic logic [1:0] decode_pos(
        input logic [1:0]        wired,
        input spv_pkg::spv_aux_s aux,
        input logic              run,
        input logic              settling
    );
        logic [1:0] code;
        code = spv_pkg::POS_FAULT;
        if (wired == spv_pkg::WIRED_BOTH) begin
            if (aux.closed_side != aux.open_side) begin
                code = aux.closed_side ? spv_pkg::POS_CLOSED
                                       : spv_pkg::POS_OPEN;
            // equal contacts depend on the timer
            end else if (run) begin
                code = spv_pkg::POS_INTER;
            end else begin
                code = spv_pkg::POS_FAULT;
            end
        end else if (wired == spv_pkg::WIRED_CLOSE) begin
            if (settling) begin
                code = spv_pkg::POS_INTER;
            end else if (aux.closed_side) begin
                code = spv_pkg::POS_CLOSED;
            end else if (run) begin
                code = spv_pkg::POS_INTER;
            end else begin
                code = spv_pkg::POS_OPEN;
            end
        end else if (wired == spv_pkg::WIRED_OPEN) begin
            if (settling) begin
                code = spv_pkg::POS_INTER;
            end else if (aux.open_side) begin
                code = spv_pkg::POS_OPEN;
            end else if (run) begin
                code = spv_pkg::POS_INTER;
            end else begin
                code = spv_pkg::POS_CLOSED;
            end
        end else begin
            code = spv_pkg::POS_FAULT;
        end
        return code;
    endfunction

    // A zero time would wrap and expire only on the 65536th tick, so it is stretched
    function automatic logic [spv_pkg::TIME_W-1:0] time_or_one(
        input logic [spv_pkg::TIME_W-1:0] t
    );
        return (t == spv_pkg::TIME_ZERO) ? spv_pkg::TIME_ONE : t;
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        n       = s;
        addr_ok = hsel && hready && htrans[spv_pkg::HTRANS_ACT_BIT];
        rd_addr = haddr[spv_pkg::ADDR_W-1:0];
        wr_cmd  = s.ahb_wr && (s.ahb_addr == spv_pkg::ADDR_CMD);
        // close trigger on rising edge or register write
        req_close = (cmd_in.close && !s.req_prev.close) ||
                    (wr_cmd && hwdata[spv_pkg::CMD_CLOSE_BIT]);
        // open trigger on rising edge or register write
        req_open  = (cmd_in.open && !s.req_prev.open) ||
                    (wr_cmd && hwdata[spv_pkg::CMD_OPEN_BIT]);
        aux_chg = (aux_in != s.aux_prev);
        tick    = (s.prescale == spv_pkg::PRESC_LAST);
        expire  = tick && (s.remain == spv_pkg::TIME_ONE);
        single  = (s.wired == spv_pkg::WIRED_CLOSE) ||
                  (s.wired == spv_pkg::WIRED_OPEN);
        busy    = ((s.phase == spv_pkg::PH_MOVE) && s.superv) ||
                  (s.phase == spv_pkg::PH_SETTLE);
        target  = s.dir_close ? spv_pkg::POS_CLOSED : spv_pkg::POS_OPEN;
        reached = (decode_pos(s.wired, aux_in, 1'b0, 1'b0) == target);

        n.aux_prev = aux_in;
        n.req_prev = cmd_in;
        n.hready   = 1'b1;
        n.hrdata   = 32'h0000_0000;

        // A held result lasts until the contacts move again or a new command starts
        if (aux_chg) begin
            n.hold_valid = 1'b0;
        end

        case (s.phase)
            spv_pkg::PH_IDLE: begin
                // Open wins when both arrive together
                if (req_open || req_close) begin
                    n.phase      = spv_pkg::PH_MOVE;
                    n.dir_close  = !req_open;
                    if (s.wired == spv_pkg::WIRED_BOTH) begin
                        n.superv = 1'b1;
                    end else if (s.wired == spv_pkg::WIRED_CLOSE) begin
                        n.superv = !req_open;
                    end else if (s.wired == spv_pkg::WIRED_OPEN) begin
                        n.superv = req_open;
                    end else begin
                        n.superv = 1'b0;
                    end
                    // load travel time for the direction
                    n.remain = time_or_one(req_open ? s.move_open
                                                    : s.move_close);
                    n.prescale      = spv_pkg::PRESC_ZERO;
                    n.success       = 1'b0;
                    n.hold_valid    = 1'b0;
                    n.cmd_out.close = !req_open;
                    n.cmd_out.open  = req_open;
                end
            end
            spv_pkg::PH_MOVE: begin
                n.prescale = tick ? spv_pkg::PRESC_ZERO
                                  : s.prescale + spv_pkg::PRESC_ONE;
                if (tick) begin
                    n.remain = s.remain - spv_pkg::TIME_ONE;
                end
                if (reached) begin
                    n.phase   = spv_pkg::PH_IDLE;
                    n.cmd_out = '{close: 1'b0, open: 1'b0};
                    n.success = s.superv;
                end else if (expire) begin
                    n.phase   = spv_pkg::PH_IDLE;
                    n.cmd_out = '{close: 1'b0, open: 1'b0};
                    if (s.superv && single &&
                        (s.settle != spv_pkg::TIME_ZERO)) begin
                        n.phase    = spv_pkg::PH_SETTLE;
                        n.remain   = s.settle;
                        n.prescale = spv_pkg::PRESC_ZERO;
                    end else if (s.superv) begin
                        n.hold_valid = 1'b1;
                        n.hold_code  = spv_pkg::POS_FAULT;
                    end
                end
            end
            spv_pkg::PH_SETTLE: begin
                n.prescale = tick ? spv_pkg::PRESC_ZERO
                                  : s.prescale + spv_pkg::PRESC_ONE;
                if (tick) begin
                    n.remain = s.remain - spv_pkg::TIME_ONE;
                end
                if (expire) begin
                    n.phase      = spv_pkg::PH_IDLE;
                    n.hold_valid = 1'b1;
                    n.hold_code  = target;
                end
            end
            default: begin
                n.phase = spv_pkg::PH_IDLE;
            end
        endcase

        shown = s.hold_valid ? s.hold_code
                             : decode_pos(s.wired, aux_in, busy,
                                          s.phase == spv_pkg::PH_SETTLE);
        n.code = shown;
        n.flags.closed = (shown == spv_pkg::POS_CLOSED);
        n.flags.open   = (shown == spv_pkg::POS_OPEN);
        n.flags.inter  = (shown == spv_pkg::POS_INTER);
        n.flags.fault  = (shown == spv_pkg::POS_FAULT);
        n.single = single;

        // Register writes land in the data phase
        if (s.ahb_wr) begin
            if (s.ahb_addr == spv_pkg::ADDR_CTRL) begin
                n.wired = hwdata[spv_pkg::WIRED_MSB:spv_pkg::WIRED_LSB];
            end else if (s.ahb_addr == spv_pkg::ADDR_MOVE_CLOSE) begin
                n.move_close = hwdata[spv_pkg::TIME_W-1:0];
            end else if (s.ahb_addr == spv_pkg::ADDR_MOVE_OPEN) begin
                n.move_open = hwdata[spv_pkg::TIME_W-1:0];
            end else if (s.ahb_addr == spv_pkg::ADDR_SETTLE) begin
                n.settle = hwdata[spv_pkg::TIME_W-1:0];
            end
        end

        // Reads are latched in the address phase, zero wait states
        n.ahb_wr   = addr_ok && hwrite;
        n.ahb_addr = rd_addr;
        if (addr_ok && !hwrite) begin
            if (rd_addr == spv_pkg::ADDR_CTRL) begin
                n.hrdata[spv_pkg::WIRED_MSB:spv_pkg::WIRED_LSB] = s.wired;
            end else if (rd_addr == spv_pkg::ADDR_MOVE_CLOSE) begin
                n.hrdata[spv_pkg::TIME_W-1:0] = s.move_close;
            end else if (rd_addr == spv_pkg::ADDR_MOVE_OPEN) begin
                n.hrdata[spv_pkg::TIME_W-1:0] = s.move_open;
            end else if (rd_addr == spv_pkg::ADDR_SETTLE) begin
                n.hrdata[spv_pkg::TIME_W-1:0] = s.settle;
            end else if (rd_addr == spv_pkg::ADDR_STATUS) begin
                n.hrdata[spv_pkg::ST_CODE_MSB:spv_pkg::ST_CODE_LSB] = s.code;
                n.hrdata[spv_pkg::ST_CLOSED_BIT] = s.flags.closed;
                n.hrdata[spv_pkg::ST_OPEN_BIT]   = s.flags.open;
                n.hrdata[spv_pkg::ST_INTER_BIT]  = s.flags.inter;
                n.hrdata[spv_pkg::ST_FAULT_BIT]  = s.flags.fault;
                n.hrdata[spv_pkg::ST_SINGLE_BIT] = s.single;
                n.hrdata[spv_pkg::ST_SUCC_BIT]   = s.success;
                n.hrdata[spv_pkg::ST_CCMD_BIT]   = s.cmd_out.close;
                n.hrdata[spv_pkg::ST_OCMD_BIT]   = s.cmd_out.open;
                n.hrdata[spv_pkg::ST_BUSY_BIT]   =
                    (s.phase != spv_pkg::PH_IDLE);
                n.hrdata[spv_pkg::ST_AUXC_BIT]   = s.aux_prev.closed_side;
                n.hrdata[spv_pkg::ST_AUXO_BIT]   = s.aux_prev.open_side;
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= ST_RST;
        end else begin
            s <= n;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign hreadyout           = s.hready;
    assign hrdata              = s.hrdata;
    assign hresp               = spv_pkg::HRESP_OKAY;
    assign cmd_out             = s.cmd_out;
    assign pos_code            = s.code;
    assign pos_flags           = s.flags;
    assign single_contact_flag = s.single;
    assign switch_success_flag = s.success;

endmodule
